/* File: common/gsj_pkg.sv */
// Purpose: Shared constants for the guarded subtract/select/jump unit
// Assumes: 32-bit data, 128 general registers, five issue slots
// Notes:   Opcodes, slot limits and delays live here only
package gsj_pkg;
	// ==========================================================
	// Widths
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned RADDR_W = 7;
	localparam int unsigned OPC_W   = 8;
	localparam int unsigned SLOT_W  = 3;
	localparam int unsigned IMM7_W  = 7;
	localparam int unsigned NREGS   = 128;
	// ==========================================================
	// Operation codes
	localparam logic [7:0] OPC_SUB      = 8'h0d;
	localparam logic [7:0] OPC_SUB_IMM  = 8'h20;
	localparam logic [7:0] OPC_ZERO_SEL = 8'h2e;
	localparam logic [7:0] OPC_JMP_IMM  = 8'hb2;
	localparam logic [7:0] OPC_JMP_FALSE = 8'hb4;
	// ==========================================================
	// Issue slot limits (slots numbered 1 to 5)
	localparam logic [2:0] ALU_SLOT_LO = 3'h1;
	localparam logic [2:0] ALU_SLOT_HI = 3'h5;
	localparam logic [2:0] BR_SLOT_LO  = 3'h2;
	localparam logic [2:0] BR_SLOT_HI  = 3'h4;
	// ==========================================================
	// Timing
	localparam int unsigned ALU_LATENCY  = 1;
	localparam int unsigned BRANCH_DELAY = 3;
	localparam logic [1:0]  BR_DELAY_CNT = 2'h3;
	// Reset values
	localparam logic [31:0] PC_RESET  = 32'h0000_0000;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] INSN_STEP = 32'h0000_0004;
	// Register index that always reads zero
	localparam logic [6:0]  REG_ZERO  = 7'h00;
	// Pending branch state
	typedef enum logic [1:0] {GSJ_IDLE, GSJ_WAIT} gsj_br_state_t;
endpackage

/* File: src/gsj_regfile.sv */
// Purpose: General register file with three registered read ports
// Assumes: One write port, register zero hard-wired to zero
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ps
module gsj_regfile (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// Read ports
	input  wire logic [gsj_pkg::RADDR_W-1:0] rd_a_addr,
	input  wire logic [gsj_pkg::RADDR_W-1:0] rd_b_addr,
	input  wire logic [gsj_pkg::RADDR_W-1:0] rd_g_addr,
	output logic      [gsj_pkg::DATA_W-1:0]  rd_a_data,
	output logic      [gsj_pkg::DATA_W-1:0]  rd_b_data,
	output logic      [gsj_pkg::DATA_W-1:0]  rd_g_data,
	// Write port
	input  wire logic                     wr_en,
	input  wire logic [gsj_pkg::RADDR_W-1:0] wr_addr,
	input  wire logic [gsj_pkg::DATA_W-1:0]  wr_data
);
	import gsj_pkg::*;

	logic [DATA_W-1:0] mem_q [NREGS];

	// Storage; register zero is never written
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NREGS; i++) begin
				mem_q[i] <= REG_RESET;
			end
		end else if (wr_en && wr_addr != REG_ZERO) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Registered reads; register zero reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_a_data <= REG_RESET;
			rd_b_data <= REG_RESET;
			rd_g_data <= REG_RESET;
		end else begin
			rd_a_data <= (rd_a_addr == REG_ZERO) ? REG_RESET : mem_q[rd_a_addr];
			rd_b_data <= (rd_b_addr == REG_ZERO) ? REG_RESET : mem_q[rd_b_addr];
			rd_g_data <= (rd_g_addr == REG_ZERO) ? REG_RESET : mem_q[rd_g_addr];
		end
	end
endmodule

/* File: src/gsj_exec.sv */
// Purpose: Execute subtract, subtract-immediate, zero-select and two jumps
// Assumes: Issue logic presents one operation per valid pulse
// Notes:   Operands read from the internal register file one cycle after issue
`timescale 1ns/1ps

// What this block does
// (RQ1) Subtract opcode 13 writes first minus second source, latency one, slots 1-5.
// (RQ2) Subtraction wraps modulo two to the 32, no overflow indication.
// (RQ3) Subtract-immediate opcode 32 subtracts a 7-bit unsigned modifier 0..127.
// (RQ4) Guard bit zero gates alu destination writes; zero leaves it unchanged.
// (RQ5) Zero-select opcode 46 writes zero if first is zero, else second.
// (RQ6) Jump-if-false opcode 180 loads pc from second if first bit0 is zero.
// (RQ7) Branches only in slots 2-4; guarded jump needs guard and condition.
// (RQ8) Jump-immediate opcode 178 loads pc with 32-bit modifier, delay three.
// (RQ9) Jump-immediate with false guard falls through sequentially.
// (RQ10) Register zero always reads zero, so negate is subtract from it.
// (RQ11) Without a guard register the guard counts as true.
module gsj_exec (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rstn,
	// Issue request
	input  wire logic                        issue_valid,
	input  wire logic [gsj_pkg::OPC_W-1:0]   issue_opcode,
	input  wire logic [gsj_pkg::SLOT_W-1:0]  issue_slot,
	input  wire logic                        guard_present,
	input  wire logic [gsj_pkg::RADDR_W-1:0] guard_register,
	input  wire logic [gsj_pkg::RADDR_W-1:0] first_source_register,
	input  wire logic [gsj_pkg::RADDR_W-1:0] second_source_register,
	input  wire logic [gsj_pkg::RADDR_W-1:0] dest_register,
	input  wire logic [gsj_pkg::DATA_W-1:0]  modifier,
	// Status of the issue
	output logic                             op_rejected,
	// Destination write observation
	output logic                             dest_wr_en,
	output logic      [gsj_pkg::RADDR_W-1:0] dest_wr_addr,
	output logic      [gsj_pkg::DATA_W-1:0]  dest_wr_data,
	// Program counter
	output logic      [gsj_pkg::DATA_W-1:0]  pc,
	output logic                             branch_taken
);
	import gsj_pkg::*;

	// Is the opcode handled by this unit on the alu
	function automatic logic is_alu(input logic [OPC_W-1:0] op);
		return (op == OPC_SUB) || (op == OPC_SUB_IMM) || (op == OPC_ZERO_SEL);
	endfunction

	// Is the opcode a branch
	function automatic logic is_branch(input logic [OPC_W-1:0] op);
		return (op == OPC_JMP_FALSE) || (op == OPC_JMP_IMM);
	endfunction

	// Wrapping 32-bit difference, carry dropped
	function automatic logic [DATA_W-1:0] wrap_sub(input logic [DATA_W-1:0] a,
	                                               input logic [DATA_W-1:0] b);
		return a - b;
	endfunction

	// ==========================================================
	// Issue stage: accept, capture fields
	logic                  s1_valid_q;
	logic [OPC_W-1:0]      s1_op_q;
	logic                  s1_gpres_q;
	logic [RADDR_W-1:0]    s1_dest_q;
	logic [IMM7_W-1:0]     s1_imm7_q;
	logic [DATA_W-1:0]     s1_imm32_q;
	logic                  accept_d;
	logic                  slot_ok;

	// Slot legality per unit
	always_comb begin
		slot_ok = 1'b0;
		if (is_alu(issue_opcode)) begin
			slot_ok = (issue_slot >= ALU_SLOT_LO) && (issue_slot <= ALU_SLOT_HI); // [RQ1]
		end else if (is_branch(issue_opcode)) begin
			slot_ok = (issue_slot >= BR_SLOT_LO) && (issue_slot <= BR_SLOT_HI); // [RQ7]
		end
		accept_d = issue_valid && slot_ok;
	end

	// Capture accepted operation for the execute cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_valid_q <= 1'b0;
			s1_op_q    <= '0;
			s1_gpres_q <= 1'b0;
			s1_dest_q  <= '0;
			s1_imm7_q  <= '0;
			s1_imm32_q <= '0;
		end else begin
			s1_valid_q <= accept_d;
			s1_op_q    <= issue_opcode;
			s1_gpres_q <= guard_present;
			s1_dest_q  <= dest_register;
			s1_imm7_q  <= modifier[IMM7_W-1:0]; // [RQ3]
			s1_imm32_q <= modifier; // [RQ8]
		end
	end

	// Illegal slot or unknown opcode flagged for one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_rejected <= 1'b0;
		end else begin
			op_rejected <= issue_valid && !slot_ok;
		end
	end

	// ==========================================================
	// Register file
	logic [DATA_W-1:0] src_a;
	logic [DATA_W-1:0] src_b;
	logic [DATA_W-1:0] grd;
	logic              wr_en_d;
	logic [DATA_W-1:0] wr_data_d;

	gsj_regfile u_regs (
		.clk       (clk),
		.rstn      (rstn),
		.rd_a_addr (first_source_register),
		.rd_b_addr (second_source_register),
		.rd_g_addr (guard_register),
		.rd_a_data (src_a),
		.rd_b_data (src_b),
		.rd_g_data (grd),
		.wr_en     (wr_en_d),
		.wr_addr   (s1_dest_q),
		.wr_data   (wr_data_d)
	); // [RQ10]

	// ==========================================================
	// Execute: guard, alu result, branch decision
	logic guard_true;
	logic jump_d;
	logic [DATA_W-1:0] target_d;

	always_comb begin
		guard_true = !s1_gpres_q || grd[0]; // [RQ11]
		wr_data_d  = '0;
		wr_en_d    = 1'b0;
		jump_d     = 1'b0;
		target_d   = s1_imm32_q;
		if (s1_valid_q) begin
			unique case (s1_op_q)
				OPC_SUB: begin
					wr_data_d = wrap_sub(src_a, src_b); // [RQ1] [RQ2]
					wr_en_d   = guard_true; // [RQ4]
				end
				OPC_SUB_IMM: begin
					wr_data_d = wrap_sub(src_a, {{(DATA_W-IMM7_W){1'b0}}, s1_imm7_q}); // [RQ3]
					wr_en_d   = guard_true; // [RQ4]
				end
				OPC_ZERO_SEL: begin
					wr_data_d = (src_a == '0) ? '0 : src_b; // [RQ5]
					wr_en_d   = guard_true; // [RQ4]
				end
				OPC_JMP_FALSE: begin
					jump_d   = guard_true && !src_a[0]; // [RQ6] [RQ7]
					target_d = src_b; // [RQ6]
				end
				OPC_JMP_IMM: begin
					jump_d = guard_true; // [RQ8] [RQ9]
				end
				default: ;
			endcase
		end
	end

	// Destination write observation
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dest_wr_en   <= 1'b0;
			dest_wr_addr <= '0;
			dest_wr_data <= '0;
		end else begin
			dest_wr_en   <= wr_en_d && (s1_dest_q != REG_ZERO);
			dest_wr_addr <= s1_dest_q;
			dest_wr_data <= wr_data_d;
		end
	end

	// ==========================================================
	// Branch delay: pc keeps stepping for three cycles, then loads target
	gsj_br_state_t      br_state_q;
	logic [1:0]         br_cnt_q;
	logic [DATA_W-1:0]  br_target_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			br_state_q  <= GSJ_IDLE;
			br_cnt_q    <= '0;
			br_target_q <= PC_RESET;
		end else begin
			unique case (br_state_q)
				GSJ_IDLE: begin
					if (jump_d) begin
						br_state_q  <= GSJ_WAIT;
						br_cnt_q    <= BR_DELAY_CNT - 2'h1; // [RQ6] [RQ8]
						br_target_q <= target_d;
					end
				end
				GSJ_WAIT: begin
					if (br_cnt_q == 2'h0) begin
						br_state_q <= GSJ_IDLE;
					end else begin
						br_cnt_q <= br_cnt_q - 2'h1;
					end
				end
			endcase
		end
	end

	// Program counter: sequential step unless delayed jump lands
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pc           <= PC_RESET;
			branch_taken <= 1'b0;
		end else if (br_state_q == GSJ_WAIT && br_cnt_q == 2'h0) begin
			pc           <= br_target_q;
			branch_taken <= 1'b1;
		end else begin
			pc           <= pc + INSN_STEP; // [RQ9]
			branch_taken <= 1'b0;
		end
	end
endmodule

/* File: test/gsj_chk_assertions.sv */
// Purpose: Port checks for the guarded sub, select and jump unit
// Assumes: One clock, async active-low reset
// Notes:   Bound to gsj_exec from the bench top
`timescale 1ns/1ps
module gsj_chk import gsj_pkg::*; (
	// Clock and reset
	input logic        clk,
	input logic        rstn,
	// Issue
	input logic        issue_valid,
	input logic [7:0]  issue_opcode,
	input logic [2:0]  issue_slot,
	input logic        guard_present,
	input logic [6:0]  guard_register,
	input logic [6:0]  first_source_register,
	input logic [6:0]  dest_register,
	input logic [31:0] modifier,
	// Results
	input logic        op_rejected,
	input logic        dest_wr_en,
	input logic [6:0]  dest_wr_addr,
	input logic [31:0] dest_wr_data,
	input logic [31:0] pc,
	input logic        branch_taken
);
	logic        alu, br, alu_ok, br_ok, jmpi;
	logic [2:0]  busy_q;
	logic [31:0] neg_imm;
	// Decode of the issue fields
	assign alu = issue_valid && issue_opcode inside {OPC_SUB, OPC_SUB_IMM, OPC_ZERO_SEL};
	assign br = issue_valid && issue_opcode inside {OPC_JMP_IMM, OPC_JMP_FALSE};
	assign alu_ok = issue_slot inside {[ALU_SLOT_LO:ALU_SLOT_HI]};
	assign br_ok = issue_slot inside {[BR_SLOT_LO:BR_SLOT_HI]};
	assign jmpi = br && br_ok && busy_q == 3'h0 && issue_opcode == OPC_JMP_IMM;
	assign neg_imm = 32'h0 - {25'h0, modifier[6:0]};
	// Branch in flight; counted wide so doubtful cases are skipped
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			busy_q <= 3'h0;
		else if (br && br_ok && busy_q < 3'h2)
			busy_q <= 3'h4;
		else if (busy_q != 3'h0)
			busy_q <= busy_q - 3'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// =====================
	// Checks
	sequence s_refused;
		op_rejected ##1 !dest_wr_en;
	endsequence
	chk_wr_latency: assert property (dest_wr_en |-> $past(issue_valid, 2)
		&& dest_wr_addr == $past(dest_register, 2)) else $error("write timing");
	chk_zero_reg: assert property (dest_wr_en |-> dest_wr_addr != REG_ZERO)
		else $error("register zero written");
	chk_alu_slot: assert property (alu && !alu_ok |=> s_refused)
		else $error("bad alu slot taken");
	chk_br_slot: assert property (br && !br_ok |=> s_refused)
		else $error("bad branch slot taken");
	chk_subimm_value: assert property (alu && alu_ok && issue_opcode == OPC_SUB_IMM
		&& !guard_present && first_source_register == REG_ZERO && dest_register != REG_ZERO
		|-> ##2 dest_wr_en && dest_wr_data == $past(neg_imm, 2)) else $error("sub imm value");
	chk_guard_false: assert property (alu && alu_ok && guard_present
		&& guard_register == REG_ZERO |-> ##2 !dest_wr_en) else $error("guarded write");
	chk_jmpi_taken: assert property (jmpi && !guard_present
		|-> ##5 branch_taken && pc == $past(modifier, 5)) else $error("jump target");
	chk_jmpi_guard: assert property (jmpi && guard_present && guard_register == REG_ZERO
		|-> ##1 !branch_taken [*5]) else $error("guarded jump taken");
	chk_pc_step: assert property ($past(rstn) && !branch_taken
		|-> pc == $past(pc) + INSN_STEP) else $error("pc step");
endmodule

/* File: test/gsj_issue_model.sv */
// Purpose: Issue logic stand-in presenting one operation per valid cycle
// Assumes: Tasks are entered at a falling clock edge
// Notes:   Released fields show their inverse; a second release in a row restores them
`timescale 1ns/1ps
module gsj_issue_model (
	// Clock
	input logic         clk,
	// Issue request
	output logic        issue_valid,
	output logic [7:0]  issue_opcode,
	output logic [2:0]  issue_slot,
	output logic        guard_present,
	output logic [6:0]  guard_register,
	output logic [6:0]  first_source_register,
	output logic [6:0]  second_source_register,
	output logic [6:0]  dest_register,
	output logic [31:0] modifier
);
	logic [71:0] f_q;
	// Fields travel as one packed word
	assign {issue_opcode, issue_slot, guard_present, guard_register, first_source_register,
		second_source_register, dest_register, modifier} = f_q;
	initial begin
		issue_valid = 1'b0;
		f_q = '0;
	end
	// Hold one operation across one rising edge
	task automatic send(input logic [71:0] f);
		f_q = f;
		issue_valid = 1'b1;
		@(negedge clk);
	endtask
	// Release the request for n cycles
	task automatic idle(input int n);
		issue_valid = 1'b0;
		f_q = ~f_q;
		repeat (n) @(negedge clk);
	endtask
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the guarded sub, select and jump unit
// Assumes: Operands are built with sub-immediate from register zero
// Notes:   A shadow register model predicts every write and jump
`timescale 1ns/1ps
module tb;
	import gsj_pkg::*;
	logic        clk, rstn, issue_valid, guard_present, op_rejected, dest_wr_en, branch_taken;
	logic [7:0]  issue_opcode;
	logic [2:0]  issue_slot;
	logic [6:0]  guard_register, first_source_register, second_source_register;
	logic [6:0]  dest_register, dest_wr_addr;
	logic [31:0] modifier, dest_wr_data, pc;
	logic [38:0] wq[$], jq[$];
	int unsigned regs [128];
	int          bad_count, total_checks, exp_rej, seen_rej;
	gsj_issue_model u_iss (.*);
	gsj_exec u_dut (.*);
	// Compare and count
	task automatic check(input logic [38:0] e, input logic [38:0] g);
		total_checks++;
		if (e !== g) begin
			bad_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Predict an operation, then present it
	task automatic op(input logic [7:0] o, input logic [2:0] s, input logic gp,
		input logic [6:0] g, a, b, d, input logic [31:0] m, input int gap);
		logic al, ok, tk;
		al = o inside {OPC_SUB, OPC_SUB_IMM, OPC_ZERO_SEL};
		ok = al ? s inside {[ALU_SLOT_LO:ALU_SLOT_HI]} :
			o inside {OPC_JMP_IMM, OPC_JMP_FALSE} && s inside {[BR_SLOT_LO:BR_SLOT_HI]};
		tk = ok && (!gp || regs[g][0]);
		exp_rej += !ok;
		if (tk && al && d != 0) begin
			case (o)
				OPC_SUB: regs[d] = regs[a] - regs[b];
				OPC_SUB_IMM: regs[d] = regs[a] - m[6:0];
				default: regs[d] = regs[a] == 0 ? 0 : regs[b];
			endcase
			wq.push_back({d, regs[d]});
		end
		if (tk && o == OPC_JMP_IMM) jq.push_back(m);
		if (tk && o == OPC_JMP_FALSE && !regs[a][0]) jq.push_back(regs[b]);
		u_iss.send({o, s, gp, g, a, b, d, m});
		if (gap > 0) u_iss.idle(gap);
	endtask
	// Score results half a cycle after their edge
	always @(negedge clk) if (rstn) begin
		if (op_rejected === 1'b1) seen_rej++;
		if (dest_wr_en === 1'b1) check(wq.size() ? wq.pop_front() : '1, {dest_wr_addr, dest_wr_data});
		if (branch_taken === 1'b1) check(jq.size() ? jq.pop_front() : '1, {7'h0, pc});
	end
	// Print counts and verdict, then stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Main sequence
	initial begin
		logic [7:0] opc [6];
		opc = '{OPC_SUB, OPC_SUB_IMM, OPC_ZERO_SEL, OPC_JMP_FALSE, OPC_JMP_IMM, 8'h27};
		rstn = 1'b0;
		void'($urandom(32'haeaf));
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		// Back-to-back loads, immediates at both ends
		for (int i = 1; i < 16; i++)
			op(OPC_SUB_IMM, 3'(i % 5 + 1), 1'b0, 7'($urandom), 0, 0, 7'(i),
				i == 1 ? 127 : i == 2 ? 0 : $urandom, 0);
		u_iss.idle(2);
		$display("test load done");
		// Negate through register zero, then wrapping differences
		for (int i = 1; i < 8; i++) op(OPC_SUB, 3'(i % 5 + 1), 0, 0, 0, 7'(i), 7'(i + 16), 0, 2);
		for (int i = 1; i < 8; i++) op(OPC_SUB, 3'h5, 0, 0, 7'(i), 7'(i + 16), 7'(i + 24), 0, 2);
		$display("test negate done");
		// Every code in every slot, random guards and operands
		for (int r = 0; r < 3; r++)
			foreach (opc[k])
				for (int s = 0; s < 8; s++)
					op(opc[k], 3'(s), 1'($urandom), 7'($urandom % 9), 7'($urandom % 32),
						7'($urandom % 32), 7'($urandom % 32), $urandom, k > 2 ? 4 : 2);
		u_iss.idle(8);
		$display("test sweep done");
		check(exp_rej, seen_rej);
		check(wq.size() + jq.size(), 0);
		end_of_test();
	end
endmodule
bind gsj_exec gsj_chk u_chk (.*);
